// >>> src/hdsc_consts.svh
`ifndef HDSC_CONSTS_SVH
`define HDSC_CONSTS_SVH
// Register byte offsets
`define HDSC_OFF_CTRL       4'h0
`define HDSC_OFF_STATUS     4'h4
`define HDSC_OFF_FAULT      4'h8
// Control register fields
`define HDSC_CTRL_ENABLE    0
`define HDSC_CTRL_HALT      1
`define HDSC_CTRL_STEP      2
`define HDSC_CTRL_MASK      3
// Status register fields
`define HDSC_STAT_HALTED    0
`define HDSC_STAT_STEPPING  1
// Fault status fields, write one to clear
`define HDSC_FLT_HALT       0
`define HDSC_FLT_BREAKPOINT_INSTRUCTION       1
`define HDSC_FLT_WATCH      2
`define HDSC_FLT_VCATCH     3
`define HDSC_FLT_EXTERNAL   4
// Reset values
`define HDSC_CTRL_RESET     4'h0
`define HDSC_FAULT_RESET    5'h00
// AXI responses
`define HDSC_RESP_OKAY      2'h0
`define HDSC_RESP_SLVERR    2'h2
`endif

// >>> src/hdsc_pkg.sv
package hdsc_pkg;
  // Core run state as seen by debug control
  typedef enum logic [1:0] {
    HDSC_RUN,
    HDSC_HALTED,
    HDSC_STEP_GO,
    HDSC_STEP_WAIT
  } hdsc_state_t;

  // Per-instruction event candidates from the core
  typedef struct packed {
    logic retire;      // Instruction completes this cycle
    logic breakpoint_instruction;        // Breakpoint instruction or match unit hit
    logic vcatch;      // Vector catch match
    logic fetch_fault; // Protection, execute-never or bus error on fetch
    logic undef;       // Undefined instruction escalated
    logic data_fault;  // Protection fault on data access
    logic watch;       // Data or address watchpoint match
    logic exc_entry;   // Exception entry (incl. tail chain) starts
    logic handler_1st; // Next instruction is a handler's first
  } hdsc_core_ev_t;

  // Gated event outcomes toward the core
  typedef struct packed {
    logic breakpoint_instruction;
    logic vcatch;
    logic watch;
  } hdsc_evq_t;
endpackage

// >>> src/hdsc_event_filter.sv
`timescale 1ns/1ps
`default_nettype none
// Qualifies one instruction's synchronous and watchpoint events
module hdsc_event_filter (
  // Core events
  input  wire hdsc_pkg::hdsc_core_ev_t ev,
  input  wire logic                    step_due,
  // Qualified events
  output hdsc_pkg::hdsc_evq_t          evq,
  output logic                         sync_taken,
  output logic                         step_taken
);
  logic watch_ok;

  // No breakpoint from a faulted fetch; a fault turns the fetch into exception entry
  always_comb begin
    step_taken = step_due;
    // Step wins the tie; any of the three is legal to take
    evq.breakpoint_instruction   = ev.breakpoint_instruction & ~ev.fetch_fault & ~step_due;
    evq.vcatch = ev.vcatch & ~evq.breakpoint_instruction & ~step_due;
    sync_taken = step_taken | evq.breakpoint_instruction | evq.vcatch;
    // Escalated undefined makes no access, and faulted access gives no match
    watch_ok   = ~ev.undef & ~ev.data_fault & ~sync_taken;
    evq.watch  = ev.watch & watch_ok;
  end
endmodule
`default_nettype wire

// >>> src/hdsc_top.sv
// How it works
// - Step set, halt cleared: leave and step once
// - Step runs one instruction or one exception entry
// - Stepped return tail-chains: halt at new handler
// - At most one context push per step
// - Step end sets halt flag, re-enters debug
// - Mask blocks service call, tick, external interrupts
// - Halt 0 step 0 while halted: resume
// - Halt 0 step 1 while halted: step, halt
// - Halt 1 written: stay in debug state
// - Step and mask decoded only when enabled and halted
// - Enable 0: halt, step, mask ignored
// - Re-entry shows halt request and halted set
// - Sync: breakpoint, catch, step; others asynchronous
// - Faulted fetch gives no breakpoint
// - Sync debug event suppresses instruction's exceptions
// - Step event taken on following instruction
// - Any one of coinciding sync events taken
// - Escalated undefined makes no memory access
// - Protection-faulted access gives no watchpoint
// - Remaining events exclusive; async order fixed
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "hdsc_consts.svh"
module hdsc_top (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // AXI4-Lite write address
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // External debug request pin
  input  wire logic        EXT_DEBUG_REQ,
  // Core event inputs, same clock
  input  wire hdsc_pkg::hdsc_core_ev_t CORE_EV,
  // Core control outputs
  output logic             CORE_HALT,
  output logic             CORE_STEP_GO,
  output logic             CORE_MASK_INTS,
  output logic             CORE_NO_RECURSE,
  output hdsc_pkg::hdsc_evq_t CORE_EVQ,
  output logic             CORE_SUPPRESS
);
  // Run state and the debugger's control bits
  hdsc_pkg::hdsc_state_t state;
  logic        ctl_enable;
  logic        ctl_halt;
  logic        ctl_step;
  logic        ctl_mask;

  // Sticky debug event flags, cleared by writing ones
  logic [4:0]  fault;

  // Write slot: address and data may arrive in either order
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        ctl_write;
  logic        flt_write;

  // Step bookkeeping, request synchroniser and event decode
  logic        pushed;
  logic [2:0]  ext_sync;
  logic        ext_req;
  logic        halted;
  logic        step_due;
  logic        sync_taken;
  logic        step_taken;
  logic        async_halt;
  logic        enter_debug;
  logic        step_done;
  hdsc_pkg::hdsc_evq_t evq;

  // Read answer prepared from the address on the bus
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Synchronous event qualification
  hdsc_event_filter hdsc_event_filter_i (
    .ev         (CORE_EV),
    .step_due   (step_due),
    .evq        (evq),
    .sync_taken (sync_taken),
    .step_taken (step_taken)
  );

  // External request: three flops, change counts when last two agree
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ext_sync <= 3'h0;
      ext_req  <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], EXT_DEBUG_REQ};
      if (ext_sync[2] == ext_sync[1])
        ext_req <= ext_sync[2];
    end
  end

  // Write channels taken in either order; held until both present
  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Ready only while the slot is empty and no response is pending
  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
    end else begin
      S_AXI_AWREADY <= ~aw_held & ~(S_AXI_AWVALID & S_AXI_AWREADY) & ~S_AXI_BVALID & ~do_write;
      S_AXI_WREADY  <= ~w_held & ~(S_AXI_WVALID & S_AXI_WREADY) & ~S_AXI_BVALID & ~do_write;
    end
  end

  assign do_write  = aw_held & w_held & ~S_AXI_BVALID;
  assign ctl_write = do_write && (aw_addr == `HDSC_OFF_CTRL) && w_strb[0];
  assign flt_write = do_write && (aw_addr == `HDSC_OFF_FAULT) && w_strb[0];

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `HDSC_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      if (aw_addr == `HDSC_OFF_CTRL || aw_addr == `HDSC_OFF_FAULT)
        S_AXI_BRESP <= `HDSC_RESP_OKAY;
      else if (aw_addr == `HDSC_OFF_STATUS)
        S_AXI_BRESP <= `HDSC_RESP_OKAY;
      else
        S_AXI_BRESP <= `HDSC_RESP_SLVERR;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  assign halted      = (state == hdsc_pkg::HDSC_HALTED);
  assign step_due    = (state == hdsc_pkg::HDSC_STEP_WAIT) && CORE_EV.retire;
  // Fixed async order: halt request, external, watchpoint
  assign async_halt  = ctl_enable & (state == hdsc_pkg::HDSC_RUN)
                     & (ctl_halt | ext_req | evq.watch);
  assign enter_debug = ctl_enable & ~halted & (sync_taken | async_halt);
  // Step ends when the next instruction comes due or a handler is ready
  assign step_done   = (state == hdsc_pkg::HDSC_STEP_WAIT)
                     & (step_taken | CORE_EV.handler_1st);

  // Control bits; ignored while halting debug is disabled
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctl_enable <= 1'b0;
      ctl_halt   <= 1'b0;
      ctl_step   <= 1'b0;
      ctl_mask   <= 1'b0;
    end else begin
      if (ctl_write) begin
        ctl_enable <= w_data[`HDSC_CTRL_ENABLE];
        if (w_data[`HDSC_CTRL_ENABLE] && halted) begin
          ctl_halt <= w_data[`HDSC_CTRL_HALT];
          ctl_step <= w_data[`HDSC_CTRL_STEP];
          ctl_mask <= w_data[`HDSC_CTRL_MASK];
        end else if (w_data[`HDSC_CTRL_ENABLE]) begin
          ctl_halt <= w_data[`HDSC_CTRL_HALT];                              // Halt request while running
        end else begin
          // Disabling drops the ignored bits so a later enable cannot revive a stale mask
          ctl_halt <= 1'b0;
          ctl_step <= 1'b0;
          ctl_mask <= 1'b0;
        end
      end
      // Re-entry shows the halt request set again
      if (enter_debug || step_done)
        ctl_halt <= 1'b1;
    end
  end

  // Run state sequencing
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= hdsc_pkg::HDSC_RUN;
    end else if (!ctl_enable) begin
      state <= hdsc_pkg::HDSC_RUN;
    end else begin
      case (state)
        hdsc_pkg::HDSC_RUN: begin
          if (enter_debug)
            state <= hdsc_pkg::HDSC_HALTED;
        end
        hdsc_pkg::HDSC_HALTED: begin
          // Halt bit 1 keeps us here whatever step and mask say
          if (!ctl_halt && ctl_step)
            state <= hdsc_pkg::HDSC_STEP_GO;
          else if (!ctl_halt)
            state <= hdsc_pkg::HDSC_RUN;
        end
        hdsc_pkg::HDSC_STEP_GO: begin
          state <= hdsc_pkg::HDSC_STEP_WAIT;
        end
        hdsc_pkg::HDSC_STEP_WAIT: begin
          if (step_done || sync_taken)
            state <= hdsc_pkg::HDSC_HALTED;
        end
        default: begin
          state <= hdsc_pkg::HDSC_RUN;
        end
      endcase
    end
  end

  // One context push allowed per step
  // Held until the next step starts, so a late second entry cannot stack again
  always_ff @(posedge CLK) begin
    if (RESET)
      pushed <= 1'b0;
    else if (state == hdsc_pkg::HDSC_STEP_GO)
      pushed <= 1'b0;
    else if (state == hdsc_pkg::HDSC_STEP_WAIT && CORE_EV.exc_entry)
      pushed <= 1'b1;
  end

  // Sticky fault flags; a new event beats a same-cycle clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      fault <= `HDSC_FAULT_RESET;
    end else begin
      if (flt_write)
        fault <= fault & ~w_data[4:0];
      if (step_done || (enter_debug && ctl_halt))
        fault[`HDSC_FLT_HALT] <= 1'b1;
      if (enter_debug && evq.breakpoint_instruction)
        fault[`HDSC_FLT_BREAKPOINT_INSTRUCTION] <= 1'b1;
      if (enter_debug && evq.watch)
        fault[`HDSC_FLT_WATCH] <= 1'b1;
      if (enter_debug && evq.vcatch)
        fault[`HDSC_FLT_VCATCH] <= 1'b1;
      if (enter_debug && ext_req)
        fault[`HDSC_FLT_EXTERNAL] <= 1'b1;
    end
  end

  // Core control outputs, registered
  always_ff @(posedge CLK) begin
    if (RESET) begin
      CORE_HALT       <= 1'b0;
      CORE_STEP_GO    <= 1'b0;
      CORE_MASK_INTS  <= 1'b0;
      CORE_NO_RECURSE <= 1'b0;
      CORE_EVQ        <= '0;
      CORE_SUPPRESS   <= 1'b0;
    end else begin
      CORE_HALT       <= halted;
      CORE_STEP_GO    <= (state == hdsc_pkg::HDSC_STEP_GO);
      CORE_MASK_INTS  <= ctl_enable & ctl_mask;
      CORE_NO_RECURSE <= pushed | (state == hdsc_pkg::HDSC_STEP_WAIT
                                   && CORE_EV.exc_entry);
      CORE_EVQ        <= ctl_enable ? evq : '0;
      CORE_SUPPRESS   <= ctl_enable & sync_taken;
    end
  end

  // Read data mux; disabled control bits read as zero
  always_comb begin
    next_rdata = 32'h0;
    next_rresp = `HDSC_RESP_OKAY;
    if (S_AXI_ARADDR == `HDSC_OFF_CTRL) begin
      next_rdata[`HDSC_CTRL_ENABLE] = ctl_enable;
      next_rdata[`HDSC_CTRL_HALT]   = ctl_enable & ctl_halt;
      next_rdata[`HDSC_CTRL_STEP]   = ctl_enable & ctl_step;
      next_rdata[`HDSC_CTRL_MASK]   = ctl_enable & ctl_mask;
    end else if (S_AXI_ARADDR == `HDSC_OFF_STATUS) begin
      next_rdata[`HDSC_STAT_HALTED]   = halted;
      next_rdata[`HDSC_STAT_STEPPING] = (state == hdsc_pkg::HDSC_STEP_WAIT);
    end else if (S_AXI_ARADDR == `HDSC_OFF_FAULT) begin
      next_rdata[4:0] = fault;
    end else begin
      next_rresp = `HDSC_RESP_SLVERR;
    end
  end

  // Read channel: one read at a time, answer the cycle after acceptance
  // ARREADY drops while an answer waits, trading throughput for a one-word buffer
  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= `HDSC_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_RVALID & ~(S_AXI_ARVALID & S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= next_rdata;
        S_AXI_RRESP  <= next_rresp;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/hdsc_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Ties core-side outputs of the debug control block to their causes
module hdsc_checker (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RESET,
  // Core side
  input  wire hdsc_pkg::hdsc_core_ev_t CORE_EV,
  input  wire logic                    CORE_HALT,
  input  wire logic                    CORE_STEP_GO,
  input  wire logic                    CORE_MASK_INTS,
  input  wire logic                    CORE_NO_RECURSE,
  input  wire hdsc_pkg::hdsc_evq_t     CORE_EVQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // A step starts, then one instruction retires or a handler is reached
  sequence s_step_retire;
    CORE_STEP_GO ##[2:30] CORE_EV.retire;
  endsequence
  sequence s_step_handler;
    CORE_STEP_GO ##[2:30] CORE_EV.handler_1st;
  endsequence
  // Step control
  a_step_single: assert property (CORE_STEP_GO |=> !CORE_STEP_GO [*3])
    else $error("step start pulse repeated");
  a_step_end_halt: assert property (s_step_retire |-> ##[1:3] CORE_HALT)
    else $error("no halt after stepped instruction");
  a_handler_halt: assert property (s_step_handler |-> ##[1:3] CORE_HALT)
    else $error("no halt at handler start");
  a_push_once: assert property ($rose(CORE_NO_RECURSE) |-> $past(CORE_EV.exc_entry))
    else $error("push marker without exception entry");
  a_mask_halted: assert property ($rose(CORE_MASK_INTS) |-> CORE_HALT)
    else $error("interrupt mask rose while running");
  // Event qualification, one cycle late
  a_fetch_no_breakpoint_instruction: assert property (CORE_EV.fetch_fault |=> !CORE_EVQ.breakpoint_instruction)
    else $error("breakpoint on faulted fetch");
  a_undef_no_watch: assert property (CORE_EV.undef |=> !CORE_EVQ.watch)
    else $error("watchpoint on escalated undefined");
  a_mpu_no_watch: assert property (CORE_EV.data_fault |=> !CORE_EVQ.watch)
    else $error("watchpoint on faulted access");
endmodule
bind hdsc_top hdsc_checker hdsc_checker_i (.CLK(CLK), .RESET(RESET), .CORE_EV(CORE_EV),
  .CORE_HALT(CORE_HALT), .CORE_STEP_GO(CORE_STEP_GO), .CORE_MASK_INTS(CORE_MASK_INTS),
  .CORE_NO_RECURSE(CORE_NO_RECURSE), .CORE_EVQ(CORE_EVQ));
`default_nettype wire

// >>> testbench/hdsc_dbg_master.sv
`timescale 1ns/1ps
`default_nettype none
// Debugger on the register bus: one write or one read at a time
module hdsc_dbg_master (
  // Clock and write channels
  input  wire logic        clk,
  output logic [3:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels
  output logic [3:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Read answer taken at the edge where it is seen
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/hdsc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "hdsc_consts.svh"
// Debugger and core stand-in around the debug control block
module hdsc_top_test;
  logic                    clk;
  logic                    reset = 1'b1;
  logic                    ext = 1'b0;
  hdsc_pkg::hdsc_core_ev_t ev = '0;
  hdsc_pkg::hdsc_evq_t     evq;
  logic                    halt, go, mask, norec, supp;
  logic [3:0]              awaddr, wstrb, araddr;
  logic [31:0]             wdata, rdata;
  logic [1:0]              bresp, rresp;
  logic                    awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  int                      fail_count = 0, comparisons = 0, cycles = 0, go_count = 0;
  hdsc_top hdsc_top_i (.CLK(clk), .RESET(reset),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr), .EXT_DEBUG_REQ(ext), .CORE_EV(ev), .CORE_HALT(halt),
    .CORE_STEP_GO(go), .CORE_MASK_INTS(mask), .CORE_NO_RECURSE(norec), .CORE_EVQ(evq),
    .CORE_SUPPRESS(supp));
  hdsc_dbg_master hdsc_dbg_master_i (.clk(clk), .awaddr(awaddr), .awvalid(awv),
    .awready(awr), .wdata(wdata), .wstrb(wstrb), .wvalid(wv), .wready(wrd), .bresp(bresp),
    .bvalid(bv), .bready(br), .araddr(araddr), .arvalid(arv), .arready(arr), .rdata(rdata),
    .rresp(rresp), .rvalid(rv), .rready(rr));
  // Compare, count, report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bus helpers; offset 0xC is unmapped and must be refused
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    hdsc_dbg_master_i.wr(a, d, r);
    check(r, `HDSC_RESP_OKAY);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic [1:0] r;
    hdsc_dbg_master_i.rd(a, d, r);
    check(r, (a == 4'hC) ? `HDSC_RESP_SLVERR : `HDSC_RESP_OKAY);
  endtask
  task automatic fault_chk(input logic [31:0] exp);
    logic [31:0] d;
    rd(`HDSC_OFF_FAULT, d);
    check(d, exp);
    wr(`HDSC_OFF_FAULT, exp);
  endtask
  // Bounded wait on the debug state output
  task automatic wait_halt(input logic exp);
    for (int n = 0; n < 40 && halt !== exp; n++) @(posedge clk);
    check(halt, exp);
  endtask
  task automatic pulse(input hdsc_pkg::hdsc_core_ev_t v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
  endtask
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`HDSC_OFF_CTRL, d);
    check(d, 32'h0);
    rd(`HDSC_OFF_STATUS, d);
    check(d, 32'h0);
    fault_chk(32'h0);
    rd(4'hC, d);
    hdsc_dbg_master_i.wr(4'hC, 32'h1, r);
    check(r, `HDSC_RESP_SLVERR);
    check({halt, go, mask, norec}, 4'h0);
    $display("test reset done");
  endtask
  task automatic t_halt();
    int g;
    wr(`HDSC_OFF_CTRL, 32'h3);
    wait_halt(1'b1);
    fault_chk(32'h1);
    g = go_count;
    wr(`HDSC_OFF_CTRL, 32'h7);
    repeat (10) @(posedge clk);
    check({halt, go_count == g}, 2'b11);
    $display("test halt done");
  endtask
  // Plain step, or a step that becomes an exception entry
  task automatic t_step(input logic exc);
    int g;
    logic [31:0] d;
    g = go_count;
    wr(`HDSC_OFF_CTRL, 32'h5);
    for (int n = 0; n < 40 && go_count == g; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    check(halt, 1'b0);
    rd(`HDSC_OFF_STATUS, d);
    check(d, 32'h2);
    if (exc) begin
      pulse(9'h002);
      @(posedge clk);
      check({norec, halt}, 2'b10);
      pulse(9'h001);
    end else pulse(9'h100);
    wait_halt(1'b1);
    check(go_count - g, 1);
    fault_chk(32'h1);
    $display("test step done");
  endtask
  // Mask set while halt stays 1, then halt cleared alone
  task automatic t_mask();
    int g;
    wr(`HDSC_OFF_CTRL, 32'hB);
    repeat (2) @(posedge clk);
    check({mask, halt}, 2'b11);
    g = go_count;
    wr(`HDSC_OFF_CTRL, 32'h9);
    wait_halt(1'b0);
    check({mask, go_count == g}, 2'b11);
    wr(`HDSC_OFF_CTRL, 32'hB);
    wait_halt(1'b1);
    fault_chk(32'h1);
    wr(`HDSC_OFF_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    check(mask, 1'b0);
    $display("test mask done");
  endtask
  // Suppressed events first, then breakpoint, vector catch, watchpoint, external
  task automatic t_events();
    logic [8:0] tab [6];
    logic [31:0] d;
    tab = '{9'h0A0, 9'h014, 9'h00C, 9'h080, 9'h040, 9'h004};
    for (int i = 0; i < 7; i++) begin
      wr(`HDSC_OFF_CTRL, 32'h1);
      wait_halt(1'b0);
      if (i == 6) begin
        @(posedge clk);
        ext <= 1'b1;
        wait_halt(1'b1);
        ext <= 1'b0;
        fault_chk(32'h10);
      end else if (i < 3) begin
        pulse(tab[i]);
        repeat (8) @(posedge clk);
        check(halt, 1'b0);
      end else begin
        pulse(tab[i]);
        @(posedge clk);
        check({evq, supp}, {tab[i][7], tab[i][6], tab[i][2], |tab[i][7:6]});
        wait_halt(1'b1);
        rd(`HDSC_OFF_CTRL, d);
        check(d, 32'h3);
        rd(`HDSC_OFF_STATUS, d);
        check(d, 32'h1);
        fault_chk({tab[i][6], tab[i][2], tab[i][7], 1'b0});
      end
    end
    $display("test events done");
  endtask
  task automatic t_disable();
    logic [31:0] d;
    int g;
    g = go_count;
    wr(`HDSC_OFF_CTRL, 32'h0);
    wait_halt(1'b0);
    wr(`HDSC_OFF_CTRL, 32'h6);
    pulse(9'h080);
    repeat (8) @(posedge clk);
    check({halt, mask, go_count == g}, 3'b001);
    rd(`HDSC_OFF_CTRL, d);
    check(d, 32'h0);
    $display("test disable done");
  endtask
  // Clock at 10 MHz
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cycle ceiling and a running count of step starts
  always @(posedge clk) begin
    cycles++;
    if (go === 1'b1) go_count++;
    if (cycles == 6000) begin
      fail_count++;
      results();
    end
  end
  // Six reset cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_halt();
    t_step(1'b0);
    t_step(1'b1);
    t_mask();
    t_events();
    t_disable();
    results();
  end
endmodule
`default_nettype wire
